//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // Short link tick keeps the run length small
    localparam int DIV = 8;
    localparam int SH = vst_pkg::TX_SHORT_T * DIV;
    localparam int LG = vst_pkg::TX_LONG_T * DIV;
    logic CLOCK_IN = 1'b0;
    logic NRST_IN = 1'b0;
    logic TX_VALID_IN = 1'b0;
    logic TX_LAST_IN = 1'b0;
    logic [3:0] DELAY_OFFSET_FIELD_IN = 4'h3;
    logic [7:0] TX_DATA_IN = 8'h00;
    logic TX_READY_OUT, TX_BUSY_OUT, BUS_TX_OUT, BUS_RX_IN;
    logic RX_SYMBOL_VALID_OUT, CONFIG_OK_OUT;
    logic [2:0] RX_SYMBOL_OUT;
    logic [2:0] got_q[$], exp_q[$];
    logic [7:0] b0;
    int failures = 0;
    int cmp_count = 0;
    int n, t;
    int lo[5] = '{5, 38, 100, 167, 330};
    int hi[5] = '{30, 92, 159, 235, 330};
    int kind[8] = '{3, 1, 1, 2, 2, 3, 0, 4};
    always #2.5 CLOCK_IN = ~CLOCK_IN;
    vst_symbol_timing #(.LINK_DIV(DIV)) i_dut (.CLOCK_IN, .NRST_IN,
        .DELAY_OFFSET_FIELD_IN,
        .TX_DATA_IN, .TX_VALID_IN, .TX_READY_OUT, .TX_LAST_IN, .TX_BUSY_OUT,
        .BUS_TX_OUT, .BUS_RX_IN, .RX_SYMBOL_OUT, .RX_SYMBOL_VALID_OUT,
        .CONFIG_OK_OUT);
    vst_bus_node #(.DIV(DIV)) i_node (.clk_in(CLOCK_IN), .bus_tx_in(BUS_TX_OUT),
        .bus_out(BUS_RX_IN));
    always @(posedge CLOCK_IN) begin
        if (RX_SYMBOL_VALID_OUT === 1'b1) got_q.push_back(RX_SYMBOL_OUT);
    end
    function automatic logic [2:0] exp_sym(input logic act, input int us);
        if (us < vst_pkg::RX_MIN_US) return vst_pkg::SYM_INVALID;
        if (us < vst_pkg::RX_MID_US)
            return act ? vst_pkg::SYM_ONE : vst_pkg::SYM_ZERO;
        if (us < vst_pkg::RX_LONG_US)
            return act ? vst_pkg::SYM_ZERO : vst_pkg::SYM_ONE;
        if (us < vst_pkg::RX_SOF_US)
            return act ? vst_pkg::SYM_SOF : vst_pkg::SYM_EOD;
        return act ? vst_pkg::SYM_BREAK : vst_pkg::SYM_EOF;
    endfunction
    task automatic miss(input int g, input int e);
        failures++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
    endtask
    task automatic chkv(input logic [2:0] g, input logic [2:0] e);
        cmp_count++;
        if (g !== e) miss(int'(g), int'(e));
    endtask
    task automatic chkw(input int g, input int e);
        cmp_count++;
        if (g != e) miss(g, e);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge CLOCK_IN);
        NRST_IN <= 1'b0;
        repeat (4) @(posedge CLOCK_IN);
        NRST_IN <= 1'b1;
        #1 chkv(3'(BUS_TX_OUT), 3'h0);
        @(posedge CLOCK_IN);
    endtask
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(81593));
        do_reset();
        b0 = 8'($urandom);
        TX_DATA_IN <= b0;
        TX_VALID_IN <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge CLOCK_IN);
            if (TX_READY_OUT === 1'b1) begin
                n++;
                TX_DATA_IN <= 8'($urandom);
                TX_LAST_IN <= 1'($urandom);
            end
        end
        TX_VALID_IN <= 1'b0;
        chkw(n, 16);
        repeat (400) @(posedge CLOCK_IN);
        chkv(3'(BUS_TX_OUT), 3'h0);
        chkv(3'(CONFIG_OK_OUT), 3'h0);
        chkv(3'(TX_BUSY_OUT), 3'h0);
        $display("fill and refusal test done");
        i_node.w_q.delete();
        DELAY_OFFSET_FIELD_IN <= 4'h7;
        repeat (3) @(posedge CLOCK_IN);
        chkv(3'(CONFIG_OK_OUT), 3'h1);
        for (t = 0; t < 150000 && i_node.w_q.size() < 4; t++)
            @(posedge CLOCK_IN);
        chkw(i_node.w_q[1], vst_pkg::TX_SOF_T * DIV);
        chkv(3'(TX_BUSY_OUT), 3'h1);
        chkw(i_node.w_q[2], b0[7] ? LG : SH);
        chkw(i_node.w_q[3], b0[6] ? SH : LG);
        $display("transmit timing test done");
        // Reset in mid frame, then feed every symbol kind except break
        do_reset();
        got_q.delete();
        for (int i = 0; i < 8; i++) begin
            t = $urandom_range(hi[kind[i]], lo[kind[i]]);
            exp_q.push_back(exp_sym(i % 2 == 0, t));
            i_node.drive(i % 2 == 0, t);
        end
        chkw(got_q.size(), 8);
        for (int i = 0; i < 8; i++) chkv(got_q[i], exp_q[i]);
        $display("receive symbol test done");
        do_reset();
        got_q.delete();
        i_node.drive(1'b1, 250);
        i_node.drive(1'b0, 20);
        chkw(got_q.size(), 1);
        chkv(got_q[0], vst_pkg::SYM_BREAK);
        $display("break test done");
        stop_test();
    end
endmodule
`default_nettype wire

//--- bench/vst_bus_node.sv
`timescale 1ns/10ps
`default_nettype none
module vst_bus_node #(
    parameter int DIV = vst_pkg::LINK_DIV
) (
    input wire logic clk_in,
    input wire logic bus_tx_in,
    output logic bus_out
);
    logic drv_q = 1'b0;
    logic last_q = 1'b0;
    int run_q = 0;
    int w_q[$];
    // Active level dominates the shared wire
    assign bus_out = drv_q | bus_tx_in;
    // Length of each level the device sends, in clocks
    always @(posedge clk_in) begin
        if (bus_tx_in !== last_q) w_q.push_back(run_q);
        run_q <= (bus_tx_in !== last_q) ? 1 : run_q + 1;
        last_q <= bus_tx_in;
    end
    task automatic drive(input logic lvl, input int us);
        drv_q <= lvl;
        repeat (us * DIV) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- bench/vst_symbol_timing_sva.sv
`timescale 1ns/10ps
`default_nettype none
module vst_symbol_timing_sva #(
    parameter int D = vst_pkg::LINK_DIV
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] DELAY_OFFSET_FIELD_IN,
    input wire logic TX_BUSY_OUT,
    input wire logic BUS_TX_OUT,
    input wire logic BUS_RX_IN,
    input wire logic [2:0] RX_SYMBOL_OUT,
    input wire logic RX_SYMBOL_VALID_OUT,
    input wire logic CONFIG_OK_OUT
);
    // Three ticks of window slack plus synchroniser delay
    localparam int WIN = 3 * D + 8;
    localparam int SH = vst_pkg::TX_SHORT_T * D;
    localparam int LG = vst_pkg::TX_LONG_T * D;
    localparam int SOF = vst_pkg::TX_SOF_T * D;
    localparam int IFS = vst_pkg::TX_IFS_T * D;
    localparam int BRK = (vst_pkg::RX_SOF_US - 2) * D;
    localparam int EOFC = (vst_pkg::RX_EOF_US - 2) * D;
    int act_q, act_d, pas_q, pas_d, rxa_q, rxa_d, rxp_q, rxp_d;
    // Passive run saturates; reset preloads it so a first start passes
    assign act_d = NRST_IN && BUS_TX_OUT ? act_q + 1 : 0;
    assign pas_d = !NRST_IN ? IFS : BUS_TX_OUT ? 0 : pas_q + (pas_q < IFS);
    assign rxa_d = NRST_IN && BUS_RX_IN ? rxa_q + 1 : 0;
    // Idle since reset never counts as a closed frame
    assign rxp_d = !NRST_IN ? EOFC + 1 : BUS_RX_IN ? 0 : rxp_q + 1;
    always_ff @(posedge CLOCK_IN) begin
        act_q <= act_d;
        pas_q <= pas_d;
        rxa_q <= rxa_d;
        rxp_q <= rxp_d;
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    chk_cfg_rise: assert property (
        $rose(CONFIG_OK_OUT) |-> $past(DELAY_OFFSET_FIELD_IN) == 4'h7)
        else $error("config ok without offset 0111");
    chk_tx_blocked: assert property (
        !CONFIG_OK_OUT && !TX_BUSY_OUT |=> !BUS_TX_OUT)
        else $error("transmit started without valid offset");
    chk_valid_pulse: assert property (
        RX_SYMBOL_VALID_OUT |=> !RX_SYMBOL_VALID_OUT)
        else $error("symbol valid longer than one cycle");
    chk_sym_code: assert property (
        RX_SYMBOL_VALID_OUT |-> RX_SYMBOL_OUT <= vst_pkg::SYM_INVALID)
        else $error("undefined symbol code");
    chk_active_width: assert property (
        $fell(BUS_TX_OUT) |-> act_q inside {SH, LG, SOF})
        else $error("active pulse of wrong length");
    chk_passive_width: assert property (
        $rose(BUS_TX_OUT) |-> pas_q inside {SH, LG, IFS})
        else $error("passive pulse of wrong length");
    chk_break_time: assert property (
        rxa_q == BRK |-> ##[0:WIN] RX_SYMBOL_VALID_OUT &&
        RX_SYMBOL_OUT == vst_pkg::SYM_BREAK) else $error("break not seen");
    chk_eof_time: assert property (
        rxp_q == EOFC |-> ##[0:WIN] RX_SYMBOL_VALID_OUT &&
        RX_SYMBOL_OUT == vst_pkg::SYM_EOF) else $error("end of frame missed");
endmodule
bind vst_symbol_timing vst_symbol_timing_sva #(.D(LINK_DIV)) i_sva (
    .CLOCK_IN, .NRST_IN,
    .DELAY_OFFSET_FIELD_IN, .TX_BUSY_OUT, .BUS_TX_OUT, .BUS_RX_IN,
    .RX_SYMBOL_OUT, .RX_SYMBOL_VALID_OUT, .CONFIG_OK_OUT);
`default_nettype wire

//--- design/vst_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module vst_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = wp_q == rp_q;
    wire push = wr_valid_in && !full;
    wire pop = rd_ready_in && !empty;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_q[rp_q[AW-1:0]];
    always_ff @(posedge clk_in) begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- design/vst_pkg.sv
package vst_pkg;
    // Link timing clock and system clock
    localparam int CLK_MHZ = 200;
    localparam int LINK_KHZ = 1000;
    localparam int LINK_DIV = CLK_MHZ * 1000 / LINK_KHZ;
    // Delay offset setting that the symbol times hold for
    localparam logic [3:0] DELAY_OFFSET_NOMINAL = 4'h7;
    // Transmit times in us, one link tick per us
    localparam int TX_SHORT_US = 64;
    localparam int TX_LONG_US = 128;
    localparam int TX_SOF_US = 200;
    localparam int TX_EOD_US = 200;
    localparam int TX_EOF_US = 280;
    localparam int TX_IFS_US = 300;
    // Receive window bounds in us
    localparam int RX_MIN_US = 34;
    localparam int RX_MID_US = 96;
    localparam int RX_LONG_US = 163;
    localparam int RX_SOF_US = 239;
    localparam int RX_EOF_US = 320;
    localparam int TICK_W = 10;
    localparam int TX_SHORT_T = TX_SHORT_US * LINK_KHZ / 1000;
    localparam int TX_LONG_T = TX_LONG_US * LINK_KHZ / 1000;
    localparam int TX_SOF_T = TX_SOF_US * LINK_KHZ / 1000;
    localparam int TX_EOD_T = TX_EOD_US * LINK_KHZ / 1000;
    localparam int TX_EOF_T = TX_EOF_US * LINK_KHZ / 1000;
    localparam int TX_IFS_T = TX_IFS_US * LINK_KHZ / 1000;
    // Received symbol codes
    localparam logic [2:0] SYM_ZERO = 3'h0;
    localparam logic [2:0] SYM_ONE = 3'h1;
    localparam logic [2:0] SYM_SOF = 3'h2;
    localparam logic [2:0] SYM_EOD = 3'h3;
    localparam logic [2:0] SYM_EOF = 3'h4;
    localparam logic [2:0] SYM_BREAK = 3'h5;
    localparam logic [2:0] SYM_INVALID = 3'h6;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_SOF = 5'h02,
        TX_BIT = 5'h04,
        TX_EOD = 5'h08,
        TX_IFS = 5'h10
    } tx_state_type;
endpackage

//--- design/vst_symbol_timing.sv
// Function
// - A passive data zero lasts 64 us and a passive data one 128 us, within 2 us.
// - An active data zero lasts 128 us and an active data one 64 us, within 2 us.
// - Each frame opens with an active start-of-frame pulse of 200 us, within 2 us.
// - After the last bit the bus stays passive 200 us (end of data), 280 us (end of frame), 300 us before a new frame.
// - Received passive 34-96 us is zero, 96-163 us one; active 34-96 us is one, 96-163 us zero.
// - Received active 163-239 us is start of frame, passive 163-239 us end of data.
// - Received passive 239-320 us is end of frame; active of 239 us or more is break.
// - Receive window bounds may move by one link clock period from sampling.
// - All symbol durations are counted on a link timing clock of about 1 MHz.
// - The symbol durations hold when the delay offset field is 0111.
`timescale 1ns/10ps
`default_nettype none
module vst_symbol_timing #(
    parameter int FIFO_DEPTH = 16,
    parameter int LINK_DIV = vst_pkg::LINK_DIV
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] DELAY_OFFSET_FIELD_IN,
    input wire logic [7:0] TX_DATA_IN,
    input wire logic TX_VALID_IN,
    output logic TX_READY_OUT,
    input wire logic TX_LAST_IN,
    output logic TX_BUSY_OUT,
    output logic BUS_TX_OUT,
    input wire logic BUS_RX_IN,
    output logic [2:0] RX_SYMBOL_OUT,
    output logic RX_SYMBOL_VALID_OUT,
    output logic CONFIG_OK_OUT
);
    // Divider counter is eight bits wide
    if (FIFO_DEPTH < 2 || LINK_DIV < 2 || LINK_DIV > 256) begin : g_bad_cfg
        $error("FIFO depth or link divider out of range");
    end
    // Link tick divider
    logic [7:0] div_q;
    logic tick_q;
    wire div_end = div_q == 8'(LINK_DIV - 1);
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_end ? 8'h00 : div_q + 8'h01;
            tick_q <= div_end;
        end
    end
    logic cfg_q;
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN)
            cfg_q <= 1'b0;
        else
            cfg_q <= DELAY_OFFSET_FIELD_IN == vst_pkg::DELAY_OFFSET_NOMINAL;
    end
    // Transmit byte buffer; bit 8 marks the last byte of a frame
    logic [8:0] f_data;
    logic f_valid;
    logic f_pop;
    logic f_ready;
    logic rdy_q;
    // Ready drops after each write so it never promises a full slot
    wire f_push = TX_VALID_IN && rdy_q;
    vst_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(CLOCK_IN),
        .nrst_in(NRST_IN),
        .wr_data_in({TX_LAST_IN, TX_DATA_IN}),
        .wr_valid_in(f_push),
        .wr_ready_out(f_ready),
        .rd_data_out(f_data),
        .rd_valid_out(f_valid),
        .rd_ready_in(f_pop)
    );
    // Transmitter
    vst_pkg::tx_state_type st_q;
    logic [vst_pkg::TICK_W-1:0] tcnt_q;
    logic [7:0] sh_q;
    logic [2:0] bidx_q;
    logic last_q;
    logic lvl_q;
    wire cur_bit = sh_q[7];
    wire [vst_pkg::TICK_W-1:0] bit_len = (lvl_q ^ cur_bit) ?
        vst_pkg::TICK_W'(vst_pkg::TX_LONG_T) :
        vst_pkg::TICK_W'(vst_pkg::TX_SHORT_T);
    wire t_done = tick_q && (tcnt_q == vst_pkg::TICK_W'(1));
    wire start_ok = f_valid && cfg_q;
    assign f_pop = (st_q == vst_pkg::TX_IDLE && tick_q && start_ok) ||
        (st_q == vst_pkg::TX_BIT && t_done && bidx_q == 3'h0 &&
         !last_q && f_valid);
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            st_q <= vst_pkg::TX_IDLE;
            tcnt_q <= '0;
            sh_q <= 8'h00;
            bidx_q <= 3'h0;
            last_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            if (tick_q && tcnt_q != '0)
                tcnt_q <= tcnt_q - 1'b1;
            case (st_q)
                vst_pkg::TX_IDLE: begin
                    if (tick_q && start_ok) begin
                        sh_q <= f_data[7:0];
                        last_q <= f_data[8];
                        lvl_q <= 1'b1;
                        tcnt_q <= vst_pkg::TICK_W'(vst_pkg::TX_SOF_T);
                        st_q <= vst_pkg::TX_SOF;
                    end
                end
                vst_pkg::TX_SOF: begin
                    if (t_done) begin
                        lvl_q <= 1'b0;
                        bidx_q <= 3'h7;
                        st_q <= vst_pkg::TX_BIT;
                        tcnt_q <= (cur_bit) ?
                            vst_pkg::TICK_W'(vst_pkg::TX_LONG_T) :
                            vst_pkg::TICK_W'(vst_pkg::TX_SHORT_T);
                    end
                end
                vst_pkg::TX_BIT: begin
                    if (t_done) begin
                        if (bidx_q != 3'h0) begin
                            bidx_q <= bidx_q - 3'h1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            lvl_q <= !lvl_q;
                            tcnt_q <= ((!lvl_q) ^ sh_q[6]) ?
                                vst_pkg::TICK_W'(vst_pkg::TX_LONG_T) :
                                vst_pkg::TICK_W'(vst_pkg::TX_SHORT_T);
                        end else if (!last_q && f_valid) begin
                            sh_q <= f_data[7:0];
                            last_q <= f_data[8];
                            bidx_q <= 3'h7;
                            lvl_q <= !lvl_q;
                            tcnt_q <= ((!lvl_q) ^ f_data[7]) ?
                                vst_pkg::TICK_W'(vst_pkg::TX_LONG_T) :
                                vst_pkg::TICK_W'(vst_pkg::TX_SHORT_T);
                        end else begin
                            lvl_q <= 1'b0;
                            tcnt_q <= vst_pkg::TICK_W'(vst_pkg::TX_IFS_T);
                            st_q <= vst_pkg::TX_EOD;
                        end
                    end
                end
                vst_pkg::TX_EOD: begin
                    // Passive hold covers end of data, end of frame and gap
                    if (t_done)
                        st_q <= vst_pkg::TX_IDLE;
                end
                default: st_q <= vst_pkg::TX_IDLE;
            endcase
        end
    end
    logic bus_q;
    logic busy_q;
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            bus_q <= 1'b0;
            busy_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            bus_q <= lvl_q;
            busy_q <= st_q != vst_pkg::TX_IDLE;
            rdy_q <= f_ready && !f_push;
        end
    end
    assign BUS_TX_OUT = bus_q;
    assign TX_BUSY_OUT = busy_q;
    assign TX_READY_OUT = rdy_q;
    assign CONFIG_OK_OUT = cfg_q;
    // Receiver: three-stage synchroniser, level taken when the last two stages agree
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic rlvl_q;
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            rlvl_q <= 1'b0;
        end else begin
            s1_q <= BUS_RX_IN;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                rlvl_q <= s3_q;
        end
    end
    logic [vst_pkg::TICK_W-1:0] rcnt_q;
    logic [2:0] sym_q;
    logic sv_q;
    logic brk_q;
    wire edge_seen = (s2_q == s3_q) && (s3_q != rlvl_q);
    wire c_short = rcnt_q < vst_pkg::TICK_W'(vst_pkg::RX_MIN_US);
    wire c_a = rcnt_q < vst_pkg::TICK_W'(vst_pkg::RX_MID_US);
    wire c_b = rcnt_q < vst_pkg::TICK_W'(vst_pkg::RX_LONG_US);
    wire c_c = rcnt_q < vst_pkg::TICK_W'(vst_pkg::RX_SOF_US);
    wire c_d = rcnt_q < vst_pkg::TICK_W'(vst_pkg::RX_EOF_US);
    wire [2:0] act_sym = c_short ? vst_pkg::SYM_INVALID :
        c_a ? vst_pkg::SYM_ONE : c_b ? vst_pkg::SYM_ZERO :
        c_c ? vst_pkg::SYM_SOF : vst_pkg::SYM_BREAK;
    wire [2:0] pas_sym = c_short ? vst_pkg::SYM_INVALID :
        c_a ? vst_pkg::SYM_ZERO : c_b ? vst_pkg::SYM_ONE :
        c_c ? vst_pkg::SYM_EOD : vst_pkg::SYM_EOF;
    wire cnt_max = &rcnt_q;
    // Break flagged as soon as the active pulse reaches its bound
    wire brk_now = rlvl_q && !brk_q &&
        rcnt_q == vst_pkg::TICK_W'(vst_pkg::RX_SOF_US);
    // Passive end of frame reported once the idle passes its bound
    wire eof_now = !rlvl_q && !brk_q &&
        rcnt_q == vst_pkg::TICK_W'(vst_pkg::RX_EOF_US);
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            rcnt_q <= '0;
            sym_q <= vst_pkg::SYM_ZERO;
            sv_q <= 1'b0;
            brk_q <= 1'b1;
        end else begin
            sv_q <= 1'b0;
            if (edge_seen) begin
                rcnt_q <= '0;
                brk_q <= 1'b0;
                if (!brk_q) begin
                    sym_q <= rlvl_q ? act_sym : pas_sym;
                    sv_q <= 1'b1;
                end
            end else begin
                if (tick_q && !cnt_max)
                    rcnt_q <= rcnt_q + 1'b1;
                if (brk_now || eof_now) begin
                    sym_q <= brk_now ? vst_pkg::SYM_BREAK : vst_pkg::SYM_EOF;
                    sv_q <= 1'b1;
                    brk_q <= 1'b1;
                end
            end
        end
    end
    assign RX_SYMBOL_OUT = sym_q;
    assign RX_SYMBOL_VALID_OUT = sv_q;
endmodule
`default_nettype wire
